// >>> hw/dc_defines.svh
// Register map, field positions, reset values and timing constants of the duty cycle controller.
// Included by the controller and its bench; holds definitions only.
`ifndef DC_DEFINES_SVH
`define DC_DEFINES_SVH
// ====================
// Register offsets
`define OFF_CTRL 8'h00
`define OFF_WAKE 8'h04
`define OFF_RELOAD 8'h08
`define OFF_SNIFF 8'h0C
`define OFF_CMD 8'h10
`define OFF_STATUS 8'h14
// ====================
// Control bits
`define B_DE 0
`define B_SYNC_RL 1
`define B_AACK 2
`define B_SNIFF 3
`define B_SLEEP_SEL 4
`define B_EXT_CLK 5
`define F_DIV_LSB 6
`define B_IRQ_EN 8
`define CTRL_W 9
`define CTRL_RST 9'h000
// ====================
// Command bits
`define B_CMD_RX 0
`define B_CMD_TX 1
`define B_CMD_SL 2
`define B_CMD_RD 3
`define B_CMD_RL 4
`define CMD_W 5
`define CMD_NONE 5'h00
// ====================
// Field positions
`define F_PRE_LSB 0
`define F_CNT_LSB 8
`define F_LIM_LSB 0
`define F_CFE_LSB 8
`define F_ST_LSB 0
`define B_ST_ARMED 3
`define B_ST_TXROLE 4
`define B_ST_RXTMR 5
`define B_ST_CAL 6
`define F_ST_CNT_LSB 16
// ====================
// Reset values and timing
`define PRE_RST 8'h00
`define CNT_RST 8'h00
`define LIM_RST 8'h10
`define CFE_RST 3'h0
`define CFE_MAX 3'h4
`define SNIFF_DIV 6'h18
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hw/dc_pkg.sv
// Types shared by the duty cycle controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package dc_pkg;
	typedef enum logic [2:0] {st_ready, st_sleep, st_rx, st_tx, st_cal} mode_t;
endpackage

// >>> hw/duty_cycle_wakeup_sniff_ctrl.sv
// Low duty cycle wake-up and sniff controller with an AXI4-Lite register slave.
// Assumes radio status inputs come from logic on ref_clk; oscillator clocks and
// the calibration flag come from other domains and are synchronised here.
`timescale 1ns/100ps
`include "dc_defines.svh"
module duty_cycle_wakeup_sniff_ctrl #(
	parameter int PW = 8,
	parameter int CW = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rc_osc_clk,
	input wire logic gpio_clk,
	input wire logic osc_cal_done,
	input wire logic irq_pending_n,
	input wire logic tx_fifo_empty,
	input wire logic sync_detected,
	input wire logic pkt_received,
	input wire logic op_done,
	input wire logic carrier_sense_valid,
	output dc_pkg::mode_t mode_state,
	output logic rx_timer_en,
	output logic rx_abort,
	output logic wake_irq,
	output logic sleep_fifo_retain
);
	import dc_pkg::*;

	typedef struct packed {
		mode_t st;
		logic armed;
		logic tx_role;
		logic ack_ph;
		logic run;
		logic tl;
		logic rx_tmr;
		logic rx_abort;
		logic wake_irq;
		logic sniff_on;
		logic [5:0] sacc;
		logic [7:0] scnt;
		logic [2:0] rc_s;
		logic [2:0] gp_s;
		logic [1:0] cal_s;
		logic [`CTRL_W-1:0] ctrl;
		logic [PW-1:0] wpre;
		logic [CW-1:0] wcnt;
		logic [PW-1:0] rpre;
		logic [CW-1:0] rcnt;
		logic [7:0] limit;
		logic [2:0] cfe;
		logic awready;
		logic wready;
		logic aw_got;
		logic w_got;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_t;

	state_t s;
	state_t n;
	logic wake;
	logic [CW-1:0] wcount;
	logic src_tick;
	logic de;
	logic wr;
	logic fin;
	logic sexp;
	logic stick;
	logic [2:0] cfe_c;
	logic [5:0] sum;
	logic [31:0] wword;
	logic [`CMD_W-1:0] cmd;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == `OFF_CTRL || a == `OFF_WAKE || a == `OFF_RELOAD || a == `OFF_SNIFF ||
			a == `OFF_CMD || a == `OFF_STATUS;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a, input state_t v, input logic [CW-1:0] c);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			`OFF_CTRL: r[`CTRL_W-1:0] = v.ctrl;
			`OFF_WAKE: begin
				r[`F_PRE_LSB +: PW] = v.wpre;
				r[`F_CNT_LSB +: CW] = v.wcnt;
			end
			`OFF_RELOAD: begin
				r[`F_PRE_LSB +: PW] = v.rpre;
				r[`F_CNT_LSB +: CW] = v.rcnt;
			end
			`OFF_SNIFF: begin
				r[`F_LIM_LSB +: 8] = v.limit;
				r[`F_CFE_LSB +: 3] = v.cfe;
			end
			`OFF_STATUS: begin
				r[`F_ST_LSB +: 3] = v.st;
				r[`B_ST_ARMED] = v.armed;
				r[`B_ST_TXROLE] = v.tx_role;
				r[`B_ST_RXTMR] = v.rx_tmr;
				r[`B_ST_CAL] = v.cal_s[1];
				r[`F_ST_CNT_LSB +: CW] = c;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	// Entering RX; sniffing never applies to the ack wait
	function automatic state_t enter_rx(input state_t v, input logic ack);
		state_t r;
		r = v;
		r.st = st_rx;
		r.ack_ph = ack;
		r.sniff_on = v.ctrl[`B_SNIFF] & ~ack;
		r.rx_tmr = ~r.sniff_on;
		r.scnt = 8'h00;
		// Tick phase restarts too, else the sniff window loses up to one tick
		r.sacc = 6'h00;
		return r;
	endfunction

	// ====================
	// Next state
	always_comb begin
		n = s;
		n.tl = 1'b0;
		n.rx_abort = 1'b0;
		n.wake_irq = 1'b0;
		fin = 1'b0;
		de = s.ctrl[`B_DE];
		// Oscillator clocks are sampled, so they must run below a quarter of ref_clk
		n.rc_s = {s.rc_s[1:0], rc_osc_clk};
		n.gp_s = {s.gp_s[1:0], gpio_clk};
		n.cal_s = {s.cal_s[0], osc_cal_done};
		src_tick = s.ctrl[`B_EXT_CLK] ? (s.gp_s[1] & ~s.gp_s[2]) : (s.rc_s[1] & ~s.rc_s[2]);
		n.run = s.run | de;
		// Sniff tick: accumulate 2^e per cycle, fire each 24
		cfe_c = (s.cfe > `CFE_MAX) ? `CFE_MAX : s.cfe;
		sum = s.sacc + (6'h01 << cfe_c);
		stick = sum >= `SNIFF_DIV;
		n.sacc = stick ? 6'(sum - `SNIFF_DIV) : sum;
		sexp = s.sniff_on && (s.scnt >= s.limit);
		if (s.sniff_on && stick && !sexp) begin
			n.scnt = 8'(s.scnt + 8'h01);
		end
		// ====================
		// AXI4-Lite slave
		if (awvalid && s.awready) begin
			n.aw_got = 1'b1;
			n.waddr = awaddr;
		end
		if (wvalid && s.wready) begin
			n.w_got = 1'b1;
			n.wdata = wdata;
			n.wstrb = wstrb;
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		wr = s.aw_got & s.w_got & ~s.bvalid;
		wword = merge(rd_word(s.waddr, s, wcount), s.wdata, s.wstrb);
		cmd = (wr && s.waddr == `OFF_CMD) ? wword[`CMD_W-1:0] : `CMD_NONE;
		if (wr) begin
			n.bvalid = 1'b1;
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bresp = mapped(s.waddr) ? `RESP_OKAY : `RESP_SLVERR;
			case (s.waddr)
				`OFF_CTRL: n.ctrl = wword[`CTRL_W-1:0];
				`OFF_WAKE: begin
					n.wpre = wword[`F_PRE_LSB +: PW];
					n.wcnt = wword[`F_CNT_LSB +: CW];
				end
				`OFF_RELOAD: begin
					n.rpre = wword[`F_PRE_LSB +: PW];
					n.rcnt = wword[`F_CNT_LSB +: CW];
				end
				`OFF_SNIFF: begin
					n.limit = wword[`F_LIM_LSB +: 8];
					n.cfe = wword[`F_CFE_LSB +: 3];
				end
				default: n.ctrl = s.ctrl;
			endcase
		end
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			n.rvalid = 1'b1;
			n.rdata = rd_word(araddr, s, wcount);
			n.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end
		n.awready = ~n.aw_got & ~n.bvalid;
		n.wready = ~n.w_got & ~n.bvalid;
		n.arready = ~n.rvalid;
		// ====================
		// Mode sequencer
		case (s.st)
			st_ready: begin
				if (cmd[`B_CMD_RX]) begin
					n = enter_rx(n, 1'b0);
					n.tx_role = 1'b0;
					n.armed = de;
				end else if (cmd[`B_CMD_TX]) begin
					n.st = st_tx;
					n.tx_role = 1'b1;
					n.armed = de;
					n.tl = 1'b1;
				end else if (cmd[`B_CMD_SL]) begin
					n.st = st_sleep;
				end
			end
			st_sleep: begin
				if (!de && !s.tx_role) begin
					n.armed = 1'b0;
				end
				if (wake && s.armed) begin
					if (!s.tx_role && de) begin
						n = enter_rx(n, 1'b0);
						n.wake_irq = s.ctrl[`B_IRQ_EN];
					end else if (s.tx_role && !tx_fifo_empty) begin
						n.st = st_tx;
						n.wake_irq = s.ctrl[`B_IRQ_EN];
					end
				end
			end
			st_rx: begin
				if (sexp) begin
					if (carrier_sense_valid) begin
						n.sniff_on = 1'b0;
						n.rx_tmr = 1'b1;
					end else begin
						n.rx_abort = 1'b1;
						fin = 1'b1;
					end
				end else if (pkt_received && s.ctrl[`B_AACK] && !s.tx_role && !s.ack_ph) begin
					n.st = st_tx;
					n.ack_ph = 1'b1;
					n.rx_tmr = 1'b0;
				end else if (op_done) begin
					fin = 1'b1;
				end
				if (sync_detected && s.ctrl[`B_SYNC_RL] && !s.tx_role) begin
					n.tl = 1'b1;
				end
			end
			st_tx: begin
				if (op_done) begin
					if (s.ctrl[`B_AACK] && s.tx_role && !s.ack_ph) begin
						n = enter_rx(n, 1'b1);
					end else begin
						fin = 1'b1;
					end
				end
			end
			st_cal: begin
				if (s.cal_s[1]) begin
					n.st = st_sleep;
				end
			end
			default: n.st = st_ready;
		endcase
		if (fin) begin
			n.ack_ph = 1'b0;
			n.rx_tmr = 1'b0;
			n.sniff_on = 1'b0;
			if (!de) begin
				n.st = st_sleep;
				n.armed = 1'b0;
			end else if (s.tx_role) begin
				n.st = st_sleep;
			end else if (irq_pending_n) begin
				n.st = st_cal;
			end else begin
				n.st = st_ready;
			end
		end
		if (cmd[`B_CMD_RL]) begin
			n.tl = 1'b1;
		end
		// Ready command overrides every mode transition and stops duty cycling
		if (cmd[`B_CMD_RD]) begin
			n.st = st_ready;
			n.armed = 1'b0;
			n.ack_ph = 1'b0;
			n.rx_tmr = 1'b0;
			n.sniff_on = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.st <= st_ready;
			s.ctrl <= `CTRL_RST;
			s.wpre <= `PRE_RST;
			s.wcnt <= `CNT_RST;
			s.rpre <= `PRE_RST;
			s.rcnt <= `CNT_RST;
			s.limit <= `LIM_RST;
			s.cfe <= `CFE_RST;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= n;
		end
	end

	wake_timer #(.PW(PW), .CW(CW)) u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(s.run),
		.src_tick(src_tick),
		.div_sel(s.ctrl[`F_DIV_LSB +: 2]),
		.load(s.tl),
		.load_pre(s.rpre),
		.load_cnt(s.rcnt),
		.per_pre(s.wpre),
		.per_cnt(s.wcnt),
		.wake(wake),
		.count(wcount)
	);

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign mode_state = s.st;
	assign rx_timer_en = s.rx_tmr;
	assign rx_abort = s.rx_abort;
	assign wake_irq = s.wake_irq;
	assign sleep_fifo_retain = s.ctrl[`B_SLEEP_SEL];

	// ====================
	// Checks
	a_wake_to_rx: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_sleep && wake && s.armed && !s.tx_role && de && !cmd[`B_CMD_RD]
		|=> s.st == st_rx && wake_irq == $past(s.ctrl[`B_IRQ_EN])) else $error("wake did not start RX");
	a_tx_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_sleep && wake && s.tx_role && tx_fifo_empty && !cmd[`B_CMD_RD]
		|=> s.st == st_sleep && !wake_irq) else $error("empty slot was not skipped");
	a_first_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_ready && cmd[`B_CMD_TX] && !cmd[`B_CMD_RX] && !cmd[`B_CMD_RD]
		|=> s.st == st_tx && s.tl) else $error("first TX missing or not reloaded");
	a_reload_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cmd[`B_CMD_RL] |=> s.tl ##1 wcount == $past(s.rcnt)) else $error("reload command ignored");
	a_sync_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_rx && sync_detected && s.ctrl[`B_SYNC_RL] && !s.tx_role |=> s.tl)
		else $error("sync word did not reload timer");
	a_irq_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fin && de && !s.tx_role && !irq_pending_n && !cmd[`B_CMD_RD] |=> s.st == st_ready)
		else $error("pending irq did not hold ready");
	a_cal_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fin && de && !s.tx_role && irq_pending_n && !cmd[`B_CMD_RD]
		|=> s.st == st_cal ##1 (s.st == st_cal || s.st == st_sleep || s.st == st_ready))
		else $error("no calibration wait before sleep");
	a_stop_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fin && !de && !cmd[`B_CMD_RD] |=> s.st == st_sleep && !s.armed) else $error("disabled op did not sleep");
	a_sniff_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_rx && sexp && !carrier_sense_valid |=> rx_abort && s.st != st_rx) else $error("RX not aborted");
	a_sniff_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.st == st_rx && sexp && carrier_sense_valid && !cmd[`B_CMD_RD] |=> rx_timer_en && !s.sniff_on)
		else $error("valid carrier did not enable RX timer");
endmodule // duty_cycle_wakeup_sniff_ctrl

// >>> hw/wake_timer.sv
// Wake-up timer: source divider, prescaler and counter.
// Assumes src_tick is a one-cycle pulse already synchronised to ref_clk.
`timescale 1ns/100ps
module wake_timer #(
	parameter int PW = 8,
	parameter int CW = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic src_tick,
	input wire logic [1:0] div_sel,
	input wire logic load,
	input wire logic [PW-1:0] load_pre,
	input wire logic [CW-1:0] load_cnt,
	input wire logic [PW-1:0] per_pre,
	input wire logic [CW-1:0] per_cnt,
	output logic wake,
	output logic [CW-1:0] count
);
	typedef struct packed {
		logic [2:0] div;
		logic [PW-1:0] pre;
		logic [CW-1:0] cnt;
		logic wake;
	} tmr_t;

	tmr_t s;
	tmr_t n;
	logic [2:0] mask;

	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		case (sel)
			2'h0: div_mask = 3'h0;
			2'h1: div_mask = 3'h1;
			2'h2: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction

	// ====================
	// Count down
	always_comb begin
		n = s;
		n.wake = 1'b0;
		mask = div_mask(div_sel);
		if (load) begin
			n.pre = load_pre;
			n.cnt = load_cnt;
			n.div = 3'h0;
		end else if (run && src_tick) begin
			n.div = s.div + 3'h1;
			if ((s.div & mask) == mask) begin
				if (s.pre != '0) begin
					n.pre = PW'(s.pre - 1'b1);
				end else begin
					n.pre = per_pre;
					if (s.cnt != '0) begin
						n.cnt = CW'(s.cnt - 1'b1);
					end else begin
						n.cnt = per_cnt;
						n.wake = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign wake = s.wake;
	assign count = s.cnt;

	a_load_value: assert property (@(posedge ref_clk) disable iff (!rst_n) load |=> count == $past(load_cnt))
		else $error("wake timer did not take reload value");
	a_wake_reload: assert property (@(posedge ref_clk) disable iff (!rst_n) wake |-> count == $past(per_cnt))
		else $error("wake timer did not reload period after wake");
endmodule // wake_timer

// >>> sim/duty_cycle_wakeup_sniff_ctrl_tb.sv
// Bench of the duty cycle controller: register checks and mode scenarios.
// Assumes the host model speaks AXI4-Lite; radio inputs are driven here.
`timescale 1ns/100ps
`include "dc_defines.svh"
module duty_cycle_wakeup_sniff_ctrl_tb;
	import dc_pkg::*;
	localparam logic [31:0] de_bit = 32'h0000_0001 << `B_DE;
	localparam logic [31:0] srl_bit = 32'h0000_0001 << `B_SYNC_RL;
	localparam logic [31:0] aack_bit = 32'h0000_0001 << `B_AACK;
	localparam logic [31:0] snf_bit = 32'h0000_0001 << `B_SNIFF;
	localparam logic [31:0] ss_bit = 32'h0000_0001 << `B_SLEEP_SEL;
	localparam logic [31:0] irq_bit = 32'h0000_0001 << `B_IRQ_EN;
	localparam logic [31:0] ext_bit = 32'h0000_0001 << `B_EXT_CLK;
	localparam logic [31:0] div4_sel = 32'h0000_0002 << `F_DIV_LSB;
	localparam int rc_cyc = 10;
	localparam int gp_cyc = 8;
	localparam logic [7:0] ra [5] = '{`OFF_CTRL, `OFF_WAKE, `OFF_RELOAD, `OFF_SNIFF, `OFF_CMD};
	localparam logic [31:0] rv [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, `LIM_RST, 32'h0000_0000};
	localparam int es [3] = '{0, 1, 5};
	logic ref_clk, rst_n, rc_osc_clk, gpio_clk, osc_cal_done, irq_pending_n, tx_fifo_empty;
	logic sync_detected, pkt_received, op_done, carrier_sense_valid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic rx_timer_en, rx_abort, wake_irq, sleep_fifo_retain;
	mode_t mode_state;
	int bad_count = 0, checked = 0, cyc = 0, irqs = 0, aborts = 0;
	duty_cycle_wakeup_sniff_ctrl #(.PW(8), .CW(8)) i_duty_cycle_wakeup_sniff_ctrl (
		.ref_clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rc_osc_clk, .gpio_clk,
		.osc_cal_done, .irq_pending_n, .tx_fifo_empty, .sync_detected, .pkt_received, .op_done,
		.carrier_sense_valid, .mode_state, .rx_timer_en, .rx_abort, .wake_irq, .sleep_fifo_retain
	);
	host_model i_host_model (
		.ref_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);
	initial ref_clk = 1'h0;
	always #2 ref_clk = ~ref_clk;
	// RC clock: ten ref_clk cycles, phase offset so edges never coincide
	initial begin
		rc_osc_clk = 1'h0;
		#3;
		forever #20 rc_osc_clk = ~rc_osc_clk;
	end
	// GPIO wake clock: eight ref_clk cycles, well below the sampling limit
	initial gpio_clk = 1'h0;
	always @(posedge ref_clk) begin
		if (cyc % 4 == 0) gpio_clk <= ~gpio_clk;
	end
	// Pulses counted every cycle, since they stand one cycle only
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (wake_irq === 1'h1) irqs <= irqs + 1;
		if (rx_abort === 1'h1) aborts <= aborts + 1;
	end
	// ====
	// Expectations and helpers
	function automatic int wake_cyc(input int p, input int c, input int t);
		return (p + 1) * (c + 1) * t;
	endfunction
	function automatic int snf_cyc(input int lim, input int e);
		return (lim * `SNIFF_DIV) >> (e > 4 ? 4 : e);
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		i_host_model.wr(a, d, r);
		chk(r, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		i_host_model.rd(a, d, r);
		chk(d & m, e);
		chk(r, er);
	endtask
	task automatic cmd(input int b);
		w(`OFF_CMD, 32'h0000_0001 << b, `RESP_OKAY);
	endtask
	task automatic wm(input mode_t m, input int lim, input logic e);
		int c;
		c = -1;
		for (int i = 0; i < lim && c < 0; i++) begin
			@(posedge ref_clk);
			if (mode_state === m) c = i;
		end
		chk(c >= 0, e);
	endtask
	task automatic op();
		@(posedge ref_clk);
		op_done <= 1'h1;
		@(posedge ref_clk);
		op_done <= 1'h0;
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge ref_clk);
		bad_count++;
		end_sim();
	end
	// ====
	// Main sequence
	initial begin
		int n;
		int t1;
		logic [7:0] rc;
		rst_n = 1'h0;
		osc_cal_done = 1'h0;
		irq_pending_n = 1'h1;
		tx_fifo_empty = 1'h1;
		sync_detected = 1'h0;
		pkt_received = 1'h0;
		op_done = 1'h0;
		carrier_sense_valid = 1'h0;
		void'($urandom(32'hd3e834ea));
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'h1;
		foreach (ra[i]) rd(ra[i], 32'hffff_ffff, rv[i], `RESP_OKAY);
		rd(8'h18, 32'hffff_ffff, 32'h0000_0000, `RESP_SLVERR);
		w(8'h18, 32'h0000_0001, `RESP_SLVERR);
		w(`OFF_STATUS, 32'h0000_0003, `RESP_OKAY);
		rd(`OFF_STATUS, 32'h0000_0007, st_ready, `RESP_OKAY);
		fin("registers");
		osc_cal_done <= 1'h1;
		w(`OFF_WAKE, 32'h0000_0201, `RESP_OKAY);
		w(`OFF_CTRL, de_bit | irq_bit, `RESP_OKAY);
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		op();
		wm(st_sleep, 20, 1'h1);
		wm(st_rx, 200, 1'h1);
		t1 = cyc;
		repeat (2) @(posedge ref_clk);
		n = irqs;
		op();
		wm(st_sleep, 20, 1'h1);
		wm(st_rx, 200, 1'h1);
		chk(cyc - t1, wake_cyc(1, 2, rc_cyc));
		repeat (2) @(posedge ref_clk);
		chk(irqs - n, 1);
		fin("rx period");
		irq_pending_n <= 1'h0;
		op();
		repeat (100) @(posedge ref_clk);
		chk(mode_state, st_ready);
		irq_pending_n <= 1'h1;
		cmd(`B_CMD_SL);
		wm(st_sleep, 5, 1'h1);
		wm(st_rx, 200, 1'h1);
		osc_cal_done <= 1'h0;
		op();
		repeat (30) @(posedge ref_clk);
		chk(mode_state, st_cal);
		osc_cal_done <= 1'h1;
		wm(st_sleep, 10, 1'h1);
		w(`OFF_CTRL, irq_bit, `RESP_OKAY);
		wm(st_rx, 200, 1'h0);
		cmd(`B_CMD_RD);
		wm(st_ready, 5, 1'h1);
		w(`OFF_CTRL, de_bit, `RESP_OKAY);
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		w(`OFF_CTRL, 32'h0000_0000, `RESP_OKAY);
		op();
		wm(st_sleep, 20, 1'h1);
		wm(st_rx, 200, 1'h0);
		cmd(`B_CMD_RD);
		fin("rx rules");
		w(`OFF_CTRL, de_bit | ss_bit, `RESP_OKAY);
		chk(sleep_fifo_retain, 1'h1);
		cmd(`B_CMD_TX);
		wm(st_tx, 10, 1'h1);
		op();
		wm(st_sleep, 20, 1'h1);
		wm(st_tx, 150, 1'h0);
		tx_fifo_empty <= 1'h0;
		wm(st_tx, 80, 1'h1);
		tx_fifo_empty <= 1'h1;
		op();
		wm(st_sleep, 20, 1'h1);
		w(`OFF_CTRL, ss_bit, `RESP_OKAY);
		wm(st_tx, 150, 1'h0);
		tx_fifo_empty <= 1'h0;
		wm(st_tx, 80, 1'h1);
		op();
		wm(st_sleep, 20, 1'h1);
		wm(st_tx, 150, 1'h0);
		cmd(`B_CMD_RD);
		fin("tx rules");
		w(`OFF_CTRL, de_bit | aack_bit | ss_bit, `RESP_OKAY);
		cmd(`B_CMD_TX);
		wm(st_tx, 10, 1'h1);
		op();
		wm(st_rx, 5, 1'h1);
		cmd(`B_CMD_RD);
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		pkt_received <= 1'h1;
		@(posedge ref_clk);
		pkt_received <= 1'h0;
		wm(st_tx, 5, 1'h1);
		cmd(`B_CMD_RD);
		fin("auto ack");
		w(`OFF_CTRL, de_bit | snf_bit, `RESP_OKAY);
		foreach (es[k]) begin
			w(`OFF_SNIFF, 32'(es[k] << 8) | 32'h0000_0002, `RESP_OKAY);
			cmd(`B_CMD_RX);
			wm(st_rx, 10, 1'h1);
			n = aborts;
			t1 = cyc;
			while (aborts == n && cyc - t1 < 100) @(posedge ref_clk);
			chk(cyc - t1 >= snf_cyc(2, es[k]) - 3 && cyc - t1 <= snf_cyc(2, es[k]) + 3, 1'h1);
			cmd(`B_CMD_RD);
		end
		carrier_sense_valid <= 1'h1;
		n = aborts;
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		repeat (60) @(posedge ref_clk);
		chk(rx_timer_en, 1'h1);
		chk(aborts, n);
		carrier_sense_valid <= 1'h0;
		cmd(`B_CMD_RD);
		fin("sniff");
		w(`OFF_WAKE, 32'h0000_0100, `RESP_OKAY);
		w(`OFF_CTRL, de_bit | irq_bit | ext_bit | div4_sel, `RESP_OKAY);
		cmd(`B_CMD_RL);
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		op();
		wm(st_rx, 200, 1'h1);
		t1 = cyc;
		op();
		wm(st_rx, 200, 1'h1);
		chk(cyc - t1, wake_cyc(0, 1, 4 * gp_cyc));
		cmd(`B_CMD_RD);
		fin("gpio clock");
		rc = 8'($urandom);
		w(`OFF_CTRL, de_bit | srl_bit, `RESP_OKAY);
		w(`OFF_RELOAD, {16'h0000, rc, 8'hff}, `RESP_OKAY);
		cmd(`B_CMD_RL);
		rd(`OFF_STATUS, 32'h00ff_0000, {8'h00, rc, 16'h0000}, `RESP_OKAY);
		cmd(`B_CMD_RX);
		wm(st_rx, 10, 1'h1);
		w(`OFF_RELOAD, {16'h0000, ~rc, 8'hff}, `RESP_OKAY);
		sync_detected <= 1'h1;
		@(posedge ref_clk);
		sync_detected <= 1'h0;
		rd(`OFF_STATUS, 32'h00ff_0000, {8'h00, ~rc, 16'h0000}, `RESP_OKAY);
		fin("reload");
		end_sim();
	end
endmodule // duty_cycle_wakeup_sniff_ctrl_tb

// >>> sim/host_model.sv
// Host model: AXI4-Lite master issuing configuration and commands.
// Assumes one ref_clk domain; hangs are cut by the bench watchdog.
`timescale 1ns/100ps
module host_model (
	input wire logic ref_clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 8'h00;
		awvalid = 1'h0;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		wvalid = 1'h0;
		bready = 1'h0;
		araddr = 8'h00;
		arvalid = 1'h0;
		rready = 1'h0;
	end
	// ====
	// Write: each channel released on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge ref_clk);
			// Released payload inverted so stale values never pass
			if (awvalid && awready) begin
				awvalid <= 1'h0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'h0;
				wdata <= ~d;
			end
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'h0;
				break;
			end
		end
	endtask
	// ====
	// Read
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge ref_clk);
			if (arvalid && arready) begin
				arvalid <= 1'h0;
				araddr <= ~a;
			end
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'h0;
				break;
			end
		end
	endtask
endmodule // host_model
